// ### rtl/smb_pkg.sv
// Shared constants and types of the static memory bus pin block
package smb_pkg;
    // ==========================================
    // Bank decode
    localparam int unsigned NUM_BANKS    = 8;
    localparam int unsigned BANK_LSB     = 24;
    localparam int unsigned BANK_W       = 3;
    localparam int unsigned CS_AREA_BIT  = 27;  // Chip select area where address bit 27 is clear
    localparam int unsigned PORT_H_LO    = 4;   // Banks 4..7 share port H
    localparam int unsigned PORT_H_W     = 4;
    localparam int unsigned POL_BANK_LO  = 6;   // Selects with programmable
    localparam int unsigned POL_BANK_HI  = 7;   // polarity
    // ==========================================
    // Data pins
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned LANES        = 4;
    localparam int unsigned IO_GRP_W     = 8;   // Port J and port I width
    localparam int unsigned IO_DATA_W    = 16;  // Data lines given to I/O
    // ==========================================
    // Types
    typedef struct packed {
        logic              write;
        logic [31:0]       addr;
        logic [DATA_W-1:0] wdata;
        logic [LANES-1:0]  byte_en;
    } smb_req_t;

    typedef enum logic [1:0] {
        SMB_IDLE,
        SMB_ACCESS,
        SMB_FINISH
    } smb_state_t;
endpackage : smb_pkg

// ### rtl/smb_pin_cell.sv
// Registered function/GPIO selector for a group of two-way pins
`timescale 1ns/1ps
module smb_pin_cell #(
    parameter int unsigned W = 4
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rstn_i,
    input  wire logic [W-1:0] gpio_sel_i,   // 1 picks the I/O line
    input  wire logic [W-1:0] func_out_i,
    input  wire logic [W-1:0] func_oe_n_i,
    input  wire logic [W-1:0] func_idle_i,  // Level loaded during reset, with the pin not driven
    input  wire logic [W-1:0] gpio_out_i,
    input  wire logic [W-1:0] gpio_oe_n_i,
    output logic      [W-1:0] pin_out_o,
    output logic      [W-1:0] pin_oe_n_o
);
    // ==========================================
    // Per-pin select, registered so pins come from flops
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            pin_out_o  <= func_idle_i;  // Functions rest at their idle level
            pin_oe_n_o <= '1;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (gpio_sel_i[i]) begin
                    pin_out_o[i]  <= gpio_out_i[i];
                    pin_oe_n_o[i] <= gpio_oe_n_i[i];
                end else begin
                    pin_out_o[i]  <= func_out_i[i] | 1'b0;
                    pin_oe_n_o[i] <= func_oe_n_i[i];
                end
            end
        end
    end
endmodule : smb_pin_cell

// ### rtl/smb_ctrl.sv
// External static memory bus pin controller with chip selects and muxing
`timescale 1ns/1ps
// Summary of operation
// - A low wait-ready input stretches the transfer until it goes high.
// - External bus clock toggles only during an external cycle.
// - Active external clock follows the internal bus clock rate and phase.
// - Eight chip selects, banks 0 to 5 active low.
// - Port H select bit 0 gives chip select, 1 gives the I/O line.
// - Bank 6 and 7 chip selects have programmable polarity.
// - Data port select 1 turns a data byte into port J I/O.
// - Data port select 1 turns another data byte into port I I/O.
// - Low output enable to memory during reads.
// - Four low-active byte write strobes, one per lane.
module smb_ctrl
    import smb_pkg::*;
(
    input  wire logic                 clk_sys_i,
    input  wire logic                 rstn_i,
    // User request side
    input  wire logic                 req_valid_i,
    input  wire smb_req_t             req_i,
    output logic                      req_ready_o,
    output logic                      done_o,
    output logic [DATA_W-1:0]         rdata_o,
    // Configuration
    input  wire logic [PORT_H_W-1:0]  port_h_pin_select_i,
    input  wire logic                 data_pin_port_select_i,
    input  wire logic                 bank6_cs_active_high_i,
    input  wire logic                 bank7_cs_active_high_i,
    // GPIO side of the shared pins
    input  wire logic [PORT_H_W-1:0]  io_port_h_out_i,
    input  wire logic [PORT_H_W-1:0]  io_port_h_oe_n_i,
    input  wire logic [IO_GRP_W-1:0]  io_port_j_lines_out_i,
    input  wire logic [IO_GRP_W-1:0]  io_port_j_lines_oe_n_i,
    output logic      [IO_GRP_W-1:0]  io_port_j_lines_in_o,
    input  wire logic [IO_GRP_W-1:0]  io_port_i_lines_out_i,
    input  wire logic [IO_GRP_W-1:0]  io_port_i_lines_oe_n_i,
    output logic      [IO_GRP_W-1:0]  io_port_i_lines_in_o,
    // Memory pins
    output logic                      static_read_strobe_n_o,
    output logic                      read_not_write_o,
    input  wire logic                 external_wait_ready_i,
    output logic                      external_bus_clock_out_o,
    output logic [PORT_H_LO-1:0]      bank_cs_n_o,      // Banks 0..3
    output logic [PORT_H_W-1:0]       port_h_pin_out_o, // Banks 4..7
    output logic [PORT_H_W-1:0]       port_h_pin_oe_n_o,
    output logic [LANES-1:0]          byte_write_strobe_n_o,
    input  wire logic [DATA_W-1:0]    data_pin_i,
    output logic [DATA_W-1:0]         data_pin_out_o,
    output logic [DATA_W-1:0]         data_pin_oe_n_o
);
    // ==========================================
    // Declarations
    smb_state_t          state_reg;
    smb_req_t            cur_reg;
    logic                phase_reg;
    logic                bus_tick;
    logic                wait_s1_reg, wait_s2_reg;
    logic [DATA_W-1:0]   din_s1_reg, din_s2_reg;
    logic [NUM_BANKS-1:0] bank_hit;
    logic [NUM_BANKS-1:0] cs_level;
    logic [NUM_BANKS-1:0] cs_idle;
    logic                settle_reg;
    logic [BANK_W-1:0]   bank_idx;
    logic                active;
    logic                drive_data;
    logic [DATA_W-1:0]   dfunc_oe_n;
    logic [DATA_W-1:0]   dgpio_out;
    logic [DATA_W-1:0]   dgpio_oe_n;
    logic [DATA_W-1:0]   dgpio_sel;

    // ==========================================
    // Bus clock divider: one enable pulse every second cycle
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= ~phase_reg;
        end
    end
    assign bus_tick = phase_reg;

    // ==========================================
    // Pin input synchronisers
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            wait_s1_reg <= 1'b0;
            wait_s2_reg <= 1'b0;
            din_s1_reg  <= '0;
            din_s2_reg  <= '0;
        end else begin
            wait_s1_reg <= external_wait_ready_i;
            wait_s2_reg <= wait_s1_reg;
            din_s1_reg  <= data_pin_i;
            din_s2_reg  <= din_s1_reg;
        end
    end

    // ==========================================
    // Transfer sequencer
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            state_reg <= SMB_IDLE;
            cur_reg   <= '0;
            settle_reg <= 1'b0;
            done_o    <= 1'b0;
            rdata_o   <= '0;
        end else begin
            done_o <= 1'b0;
            unique case (state_reg)
                SMB_IDLE: begin
                    if (bus_tick && req_valid_i) begin
                        cur_reg   <= req_i;
                        state_reg <= SMB_ACCESS;
                        settle_reg <= 1'b1;
                    end
                end
                SMB_ACCESS: begin
                    // Sample wait on bus clock edges only; the first tick
                    // just lets pins and data reach the synchronisers
                    if (bus_tick && settle_reg) begin
                        settle_reg <= 1'b0;
                    end else if (bus_tick && wait_s2_reg) begin
                        if (!cur_reg.write) begin
                            rdata_o <= din_s2_reg;
                        end
                        state_reg <= SMB_FINISH;
                    end
                end
                SMB_FINISH: begin
                    done_o    <= 1'b1;
                    state_reg <= SMB_IDLE;
                end
            endcase
        end
    end

    // Ready only in idle on a tick edge window
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            req_ready_o <= 1'b0;
        end else begin
            req_ready_o <= (state_reg == SMB_IDLE) && !phase_reg
                           && !(bus_tick && req_valid_i);
        end
    end

    assign active = (state_reg == SMB_ACCESS);

    // ==========================================
    // External bus clock, gated to external cycles
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            external_bus_clock_out_o <= 1'b0;
        end else if (active) begin
            external_bus_clock_out_o <= ~phase_reg;
        end else begin
            external_bus_clock_out_o <= 1'b0;
        end
    end

    // ==========================================
    // Read/write strobes
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            static_read_strobe_n_o <= 1'b1;
            read_not_write_o       <= 1'b1;
            byte_write_strobe_n_o  <= '1;
        end else begin
            static_read_strobe_n_o <= ~(active && !cur_reg.write);
            read_not_write_o       <= ~(active && cur_reg.write);
            for (int i = 0; i < LANES; i++) begin
                byte_write_strobe_n_o[i] <=
                    ~(active && cur_reg.write && cur_reg.byte_en[i]);
            end
        end
    end

    // ==========================================
    // Bank decode and chip select levels
    assign bank_idx = cur_reg.addr[BANK_LSB +: BANK_W];
    always_comb begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            bank_hit[b] = active && !cur_reg.addr[CS_AREA_BIT]
                          && (bank_idx == b[BANK_W-1:0]);
            cs_idle[b]  = 1'b1;
        end
        cs_idle[POL_BANK_LO] = ~bank6_cs_active_high_i;
        cs_idle[POL_BANK_HI] = ~bank7_cs_active_high_i;
        cs_level   = cs_idle ^ bank_hit;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            bank_cs_n_o <= '1;
        end else begin
            bank_cs_n_o <= cs_level[PORT_H_LO-1:0];
        end
    end

    // ==========================================
    // Port H pins: chip select or I/O line
    smb_pin_cell #(
        .W (PORT_H_W)
    ) u_port_h (
        .clk_sys_i   (clk_sys_i),
        .rstn_i      (rstn_i),
        .gpio_sel_i  (port_h_pin_select_i),
        .func_out_i  (cs_level[NUM_BANKS-1:PORT_H_LO]),   // Same edge as 0..3
        .func_oe_n_i ({PORT_H_W{1'b0}}),
        .func_idle_i (cs_idle[NUM_BANKS-1:PORT_H_LO]),
        .gpio_out_i  (io_port_h_out_i),
        .gpio_oe_n_i (io_port_h_oe_n_i),
        .pin_out_o   (port_h_pin_out_o),
        .pin_oe_n_o  (port_h_pin_oe_n_o)
    );

    // ==========================================
    // Data pins: bus data or port J / port I lines
    assign drive_data = active && cur_reg.write;
    always_comb begin
        dfunc_oe_n = {DATA_W{~drive_data}};
        dgpio_out  = {{(DATA_W-IO_DATA_W){1'b0}},
                      io_port_i_lines_out_i, io_port_j_lines_out_i};
        dgpio_oe_n = {{(DATA_W-IO_DATA_W){1'b1}},
                      io_port_i_lines_oe_n_i, io_port_j_lines_oe_n_i};
        dgpio_sel  = {{(DATA_W-IO_DATA_W){1'b0}},
                      {IO_DATA_W{data_pin_port_select_i}}};
    end

    smb_pin_cell #(
        .W (DATA_W)
    ) u_data (
        .clk_sys_i   (clk_sys_i),
        .rstn_i      (rstn_i),
        .gpio_sel_i  (dgpio_sel),
        .func_out_i  (cur_reg.wdata),
        .func_oe_n_i (dfunc_oe_n),
        .func_idle_i ({DATA_W{1'b0}}),
        .gpio_out_i  (dgpio_out),
        .gpio_oe_n_i (dgpio_oe_n),
        .pin_out_o   (data_pin_out_o),
        .pin_oe_n_o  (data_pin_oe_n_o)
    );

    // Synchronised I/O inputs back to the port logic
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            io_port_j_lines_in_o <= '0;
            io_port_i_lines_in_o <= '0;
        end else begin
            io_port_j_lines_in_o <= din_s2_reg[IO_GRP_W-1:0];
            io_port_i_lines_in_o <= din_s2_reg[IO_DATA_W-1:IO_GRP_W];
        end
    end
endmodule : smb_ctrl

// ### verification/smb_ctrl_props.sv
// Pin-level checks of the static memory bus block
`timescale 1ns/1ps
module smb_ctrl_props
    import smb_pkg::*;
(
    input wire logic                clk_sys_i,
    input wire logic                rstn_i,
    input wire logic                done_o,
    input wire logic [PORT_H_W-1:0] port_h_pin_select_i,
    input wire logic                bank6_cs_active_high_i,
    input wire logic                bank7_cs_active_high_i,
    input wire logic [PORT_H_W-1:0] io_port_h_out_i,
    input wire logic                static_read_strobe_n_o,
    input wire logic                read_not_write_o,
    input wire logic                external_wait_ready_i,
    input wire logic                external_bus_clock_out_o,
    input wire logic [PORT_H_LO-1:0] bank_cs_n_o,
    input wire logic [PORT_H_W-1:0] port_h_pin_out_o,
    input wire logic [PORT_H_W-1:0] port_h_pin_oe_n_o,
    input wire logic [LANES-1:0]    byte_write_strobe_n_o
);
    logic       idle;
    logic [1:0] pol_reg;
    logic [7:0] act;
    // ======
    // Polarity delayed one edge, like the registered select pins
    always_ff @(posedge clk_sys_i) begin
        pol_reg <= {bank7_cs_active_high_i, bank6_cs_active_high_i};
    end
    // Bus idle and active selects, polarity applied
    assign idle = static_read_strobe_n_o & (&byte_write_strobe_n_o)
        & read_not_write_o;
    assign act = {~port_h_pin_select_i & ~port_h_pin_oe_n_o
        & (port_h_pin_out_o ^ {~pol_reg[1], ~pol_reg[0], 2'b11}),
        ~bank_cs_n_o};
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // ======
    // Properties
    property p_clk_idle; idle && $past(idle) |-> !external_bus_clock_out_o;
    endproperty
    a_clk_idle: assert property (p_clk_idle) else $error("clock idle");
    property p_clk_rate;
        $rose(external_bus_clock_out_o) |=> $fell(external_bus_clock_out_o);
    endproperty
    a_clk_rate: assert property (p_clk_rate) else $error("clock rate");
    property p_wait; !external_wait_ready_i [*6] |=> !done_o; endproperty
    a_wait: assert property (p_wait) else $error("done in wait");
    property p_rd;
        !static_read_strobe_n_o |-> read_not_write_o && &byte_write_strobe_n_o;
    endproperty
    a_rd: assert property (p_rd) else $error("read pins");
    property p_wr; !(&byte_write_strobe_n_o) |-> !read_not_write_o;
    endproperty
    a_wr: assert property (p_wr) else $error("write dir");
    property p_rnw; !idle && !$past(idle) |-> $stable(read_not_write_o);
    endproperty
    a_rnw: assert property (p_rnw) else $error("dir moved");
    property p_cs; $onehot0(act); endproperty
    a_cs: assert property (p_cs) else $error("two selects");
    property p_cs_idle; idle && $past(idle) |-> act == 8'h00; endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("select idle");
    property p_ph; $past(rstn_i) |-> ((port_h_pin_out_o
        ^ $past(io_port_h_out_i)) & $past(port_h_pin_select_i)) == 4'h0;
    endproperty
    a_ph: assert property (p_ph) else $error("port h line");
endmodule : smb_ctrl_props

bind smb_ctrl smb_ctrl_props u_props (.clk_sys_i, .rstn_i, .done_o,
    .port_h_pin_select_i, .bank6_cs_active_high_i, .bank7_cs_active_high_i,
    .io_port_h_out_i, .static_read_strobe_n_o, .read_not_write_o,
    .external_wait_ready_i, .external_bus_clock_out_o, .bank_cs_n_o,
    .port_h_pin_out_o, .port_h_pin_oe_n_o, .byte_write_strobe_n_o);

// ### verification/smb_mem_model.sv
// Behavioural static memory on the far side of the bus pins
`timescale 1ns/1ps
module smb_mem_model (
    input  wire logic        clk_sys_i,
    input  wire logic        sel_i,     // Some chip select active
    input  wire logic        rd_n_i,
    input  wire logic [3:0]  wr_n_i,
    input  wire logic [31:0] bus_i,
    input  wire logic [7:0]  wait_i,    // Wait cycles per access
    output logic      [31:0] bus_o,
    output logic             ready_o
);
    logic [31:0] mem_reg;
    logic [31:0] last_reg = 32'h0;
    logic [7:0]  cnt_reg  = 8'h0;
    // Count selected cycles; ready low until the wait runs out
    always_ff @(posedge clk_sys_i) begin
        cnt_reg <= sel_i ? cnt_reg + 8'h01 : 8'h00;
        last_reg <= bus_o;
    end
    assign ready_o = (cnt_reg >= wait_i);
    // Released bus shows a changing pattern, not the old value
    assign bus_o = (sel_i && !rd_n_i) ? mem_reg : ~last_reg;
    // Byte lane writes
    always_ff @(posedge clk_sys_i) begin
        for (int i = 0; i < 4; i++) begin
            if (sel_i && !wr_n_i[i]) begin
                mem_reg[8*i +: 8] <= bus_i[8*i +: 8];
            end
        end
    end
endmodule : smb_mem_model

// ### verification/smb_ctrl_tb.sv
// Self-checking bench for the static memory bus pin block
`timescale 1ns/1ps
module smb_ctrl_tb
    import smb_pkg::*;
;
    typedef struct packed {
        logic wr; logic [2:0] bank; logic [31:0] data;
        logic [3:0] be; logic [7:0] wt; logic pol;
    } smb_row_t;
    logic clk_sys_i, rstn_i, req_valid_i, req_ready_o, done_o;
    logic data_pin_port_select_i, bank6_cs_active_high_i;
    logic bank7_cs_active_high_i, static_read_strobe_n_o, read_not_write_o;
    logic external_wait_ready_i, external_bus_clock_out_o;
    logic [3:0] port_h_pin_select_i, io_port_h_out_i, io_port_h_oe_n_i;
    logic [3:0] bank_cs_n_o, port_h_pin_out_o, port_h_pin_oe_n_o;
    logic [3:0] byte_write_strobe_n_o;
    logic [7:0] io_port_j_lines_out_i, io_port_j_lines_oe_n_i, wait_cyc, act;
    logic [7:0] io_port_j_lines_in_o, io_port_i_lines_out_i;
    logic [7:0] io_port_i_lines_oe_n_i, io_port_i_lines_in_o;
    logic [31:0] rdata_o, data_pin_i, data_pin_out_o, data_pin_oe_n_o;
    logic [31:0] mem_bus;
    logic [15:0] ext_pins;
    logic [11:0] seen;
    smb_req_t    req_i;
    int err_total = 0, checks_done = 0, cyc = 0;
    smb_row_t rows [8] = '{
        '{1'b1, 3'd0, 32'h11223344, 4'hf, 8'd0, 1'b0},
        '{1'b0, 3'd1, 32'h11223344, 4'hf, 8'd3, 1'b0},
        '{1'b1, 3'd2, 32'h00aa0000, 4'h4, 8'd0, 1'b0},
        '{1'b0, 3'd3, 32'h11aa3344, 4'hf, 8'd5, 1'b0},
        '{1'b1, 3'd4, 32'h55000000, 4'h8, 8'd1, 1'b0},
        '{1'b0, 3'd6, 32'h55aa3344, 4'hf, 8'd0, 1'b0},
        '{1'b1, 3'd7, 32'h00000066, 4'h1, 8'd2, 1'b1},
        '{1'b0, 3'd6, 32'h55aa3366, 4'hf, 8'd0, 1'b1}};
    smb_ctrl dut_u (.clk_sys_i, .rstn_i, .req_valid_i, .req_i, .req_ready_o,
        .done_o, .rdata_o, .port_h_pin_select_i, .data_pin_port_select_i,
        .bank6_cs_active_high_i, .bank7_cs_active_high_i, .io_port_h_out_i,
        .io_port_h_oe_n_i, .io_port_j_lines_out_i, .io_port_j_lines_oe_n_i,
        .io_port_j_lines_in_o, .io_port_i_lines_out_i, .io_port_i_lines_oe_n_i,
        .io_port_i_lines_in_o, .static_read_strobe_n_o, .read_not_write_o,
        .external_wait_ready_i, .external_bus_clock_out_o, .bank_cs_n_o,
        .port_h_pin_out_o, .port_h_pin_oe_n_o, .byte_write_strobe_n_o,
        .data_pin_i, .data_pin_out_o, .data_pin_oe_n_o);
    smb_mem_model mem_u (.clk_sys_i, .sel_i(|act),
        .rd_n_i(static_read_strobe_n_o), .wr_n_i(byte_write_strobe_n_o),
        .bus_i(data_pin_i), .wait_i(wait_cyc), .bus_o(mem_bus),
        .ready_o(external_wait_ready_i));
    // Active selects and resolved data pins
    assign act = {~port_h_pin_select_i & ~port_h_pin_oe_n_o
        & (port_h_pin_out_o ^ {~bank7_cs_active_high_i,
        ~bank6_cs_active_high_i, 2'b11}), ~bank_cs_n_o};
    always_comb begin
        for (int b = 0; b < 32; b++) begin
            data_pin_i[b] = !data_pin_oe_n_o[b] ? data_pin_out_o[b]
                : (data_pin_port_select_i && b < 16) ? ext_pins[b]
                : mem_bus[b];
        end
    end
    // Clock, pin activity log and hang limit
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    always @(negedge clk_sys_i) seen |= {~byte_write_strobe_n_o, act};
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            stop_test();
        end
    end
    // ======
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic run(input smb_row_t r);
        int n;
        n = 0;
        {bank6_cs_active_high_i, bank7_cs_active_high_i} = {2{r.pol}};
        @(negedge clk_sys_i); // Select pins settle to the new polarity
        wait_cyc = r.wt;
        req_i = {r.wr, 5'h0, r.bank, 24'h0, r.data, r.be};
        seen = '0;
        req_valid_i = 1'b1;
        while (req_ready_o !== 1'b1 && n < 50) begin
            @(negedge clk_sys_i);
            n++;
        end
        @(negedge clk_sys_i);
        req_valid_i = 1'b0;
        n = 1;
        while (done_o !== 1'b1 && n < 60) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk(32'(n >= r.wt + 5 && n <= r.wt + 12), 32'h1);
        if (!r.wr) chk(rdata_o, r.data);
        repeat (2) @(negedge clk_sys_i);
        chk(32'(seen), {20'h0, r.wr ? r.be : 4'h0, (8'h01 << r.bank)
            & ~{port_h_pin_select_i, 4'h0}});
    endtask : run
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // ======
    // Main sequence
    initial begin
        {rstn_i, req_valid_i, req_i, wait_cyc, ext_pins} = '0;
        {port_h_pin_select_i, data_pin_port_select_i, io_port_h_out_i} = '0;
        {bank6_cs_active_high_i, bank7_cs_active_high_i} = 2'b00;
        {io_port_h_oe_n_i, io_port_i_lines_oe_n_i} = '1;
        {io_port_j_lines_out_i, io_port_j_lines_oe_n_i} = 16'h00ff;
        io_port_i_lines_out_i = 8'h0;
        repeat (8) @(negedge clk_sys_i);
        chk({bank_cs_n_o, byte_write_strobe_n_o, static_read_strobe_n_o,
            external_bus_clock_out_o, port_h_pin_oe_n_o}, 32'h3fef);
        chk(data_pin_oe_n_o, 32'hffffffff);
        rstn_i = 1'b1;
        foreach (rows[k]) run(rows[k]);
        // Bank 5 pin lent to port H: write must reach no memory
        {port_h_pin_select_i, io_port_h_out_i, io_port_h_oe_n_i} = 12'h2a0;
        run('{1'b1, 3'd5, 32'h000000ee, 4'h1, 8'd0, 1'b0});
        chk(32'(port_h_pin_out_o & 4'h2), 32'h2);
        port_h_pin_select_i = 4'h0;
        run('{1'b0, 3'd7, 32'h55aa3366, 4'hf, 8'd0, 1'b0});
        // Low data bytes lent to ports J and I
        {data_pin_port_select_i, io_port_j_lines_out_i} = 9'h15a;
        {io_port_j_lines_oe_n_i, ext_pins} = 24'h003c00;
        repeat (5) @(negedge clk_sys_i);
        chk(data_pin_out_o[7:0], 8'h5a);
        chk(io_port_j_lines_in_o, 8'h5a);
        chk(data_pin_oe_n_o[15:0], 16'hff00);
        chk(io_port_i_lines_in_o, 8'h3c);
        stop_test();
    end
endmodule : smb_ctrl_tb
